// *** pkg/adc_seq_defines.svh ***
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// register byte offsets
`define OFS_CTRL_TWO      4'h0
`define OFS_CTRL_THREE    4'h4
`define OFS_CTRL_ONE      4'h8
`define OFS_RESULT        4'hC

// converter_control_two fields
`define REF_CFG_HI        15
`define REF_CFG_LO        13
`define OFFSET_CALIBRATION_ENABLE_BIT        12
`define SCAN_BIT          10
`define FILL_BIT          7
`define SPI_HI            5
`define SPI_LO            2
`define SPLIT_BIT         1
`define ALT_BIT           0
`define CTRL_TWO_WMASK    16'hF43F

// converter_control_three fields
`define CLK_SRC_BIT       15
`define SAMP_HI           12
`define SAMP_LO           8
`define DIV_HI            7
`define DIV_LO            0
`define CTRL_THREE_WMASK  16'h9FFF

// converter_control_one fields
`define TRIG_HI           7
`define TRIG_LO           5
`define START_BIT         1
`define CTRL_ONE_WMASK    16'h00E2
`define TRIG_AUTO         3'h7

`define RESET_VALUE       16'h0000
`define CONV_PERIODS      5'h0C

`endif

// *** pkg/adc_seq_pkg.sv ***
package adc_seq_pkg;

    typedef enum logic [1:0] {
        REF_INTERNAL = 2'h0,
        REF_EXT_HIGH = 2'h1,
        REF_EXT_LOW  = 2'h2,
        REF_EXT_BOTH = 2'h3
    } ref_sel_t;

    typedef struct packed {
        logic       high_reference_ext;
        logic       low_reference_ext;
        logic       inputs_to_low_ref;
        logic       use_scan_select;
        logic       mux_b_select;
        logic       sample;
        logic       convert;
    } analog_ctrl_t;

    typedef struct packed {
        logic [3:0] slot;
        logic [9:0] value;
    } result_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_SAMPLE  = 2'h1,
        ST_CONVERT = 2'h3,
        ST_DONE    = 2'h2
    } seq_state_t;

endpackage : adc_seq_pkg

// *** rtl/adc_sequence_clock_control.sv ***
// Operation
// - a 3-bit reference configuration field sits at bits 15 to 13 of control register two.
// - reference codes 000 and 1xx use internal references, 001 external high, 010 external low, 011 both external.
// - with offset calibration set, both sample-and-hold inputs are tied to the low reference.
// - with offset calibration clear, inputs follow the channel select or scan select register.
// - the scan enable bit 10 makes the converter step through the selected inputs.
// - the read-only fill status bit shows 1 while the upper half fills and 0 while the lower half fills.
// - the interrupt is raised after every (N+1)th completed sequence, N being bits 5 to 2.
// - split buffer mode gives two 8-word halves, otherwise one 16-word buffer.
// - alternate sampling uses mux A first and then B, A, B for later samples.
// - with alternate sampling clear, mux A is used for every sample.
// - clock source bit 15 of register three picks the internal RC clock when 1, the bus clock when 0.
// - auto sample time lasts its value in conversion clock periods, 1 to 31, and zero is not programmed.
// - the conversion clock period is 2 times (divider + 1) peripheral clock periods.
// - the auto sample time is used only when the trigger source field is 111.
// - the divider field is ignored when the internal RC clock is selected.
// - unimplemented bits of the control registers read as zero.
`timescale 1ns/1ns
`include "adc_seq_defines.svh"

module adc_sequence_clock_control #(
    parameter int DEPTH = 2
) (
    // clock, enable and reset
    input  wire logic                    sys_clk,
    input  wire logic                    clk_en,
    input  wire logic                    resetn,
    // wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    // analog core side
    input  wire logic                    rc_clk_tick,
    input  wire logic                    manual_trigger,
    input  wire logic [9:0]              conv_value,
    output adc_seq_pkg::analog_ctrl_t    analog_ctrl,
    // result stream
    output adc_seq_pkg::result_t         result_data,
    output logic                         result_valid,
    input  wire logic                    result_ready,
    // event
    output logic                         seq_irq
);
    import adc_seq_pkg::*;

    localparam logic [15:0] TWO_WMASK   = `CTRL_TWO_WMASK;
    localparam logic [15:0] THREE_WMASK = `CTRL_THREE_WMASK;
    localparam logic [15:0] ONE_WMASK   = `CTRL_ONE_WMASK;

    logic [1:0]  rst_sync_r;
    logic        rst_n;
    logic [1:0]  rc_sync_r;
    logic        rc_prev_r;
    logic [1:0]  trig_sync_r;
    logic        trig_prev_r;
    logic [15:0] ctrl_two_r;
    logic [15:0] ctrl_three_r;
    logic [15:0] ctrl_one_r;
    logic        fill_half_status_r;
    logic [3:0]  seq_count_r;
    logic [3:0]  slot_r;
    logic        mux_b_r;
    logic        first_sample_r;
    logic [7:0]  div_count_r;
    logic        tick;
    logic [4:0]  period_count_r;
    logic        seq_irq_r;
    seq_state_t  state_r;
    seq_state_t  state_nxt;
    logic        wb_ack_r;
    logic [31:0] wb_dat_r;
    logic        start_req;
    logic        push_ok;
    result_t     buf_mem [DEPTH];
    logic        wr_ptr_r;
    logic        rd_ptr_r;
    logic [1:0]  count_r;
    logic        buf_full;
    logic        wr_en;
    logic        rd_en;
    logic        bus_wr;
    logic [2:0]  ref_cfg;
    logic [3:0]  seq_per_irq;
    logic [4:0]  sample_time;
    logic [4:0]  sample_len;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // external inputs pass two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_sync_r   <= 2'h0;
            rc_prev_r   <= 1'b0;
            trig_sync_r <= 2'h0;
            trig_prev_r <= 1'b0;
        end else if (clk_en) begin
            rc_sync_r   <= {rc_sync_r[0], rc_clk_tick};
            rc_prev_r   <= rc_sync_r[1];
            trig_sync_r <= {trig_sync_r[0], manual_trigger};
            trig_prev_r <= trig_sync_r[1];
        end
    end

    assign ref_cfg     = ctrl_two_r[`REF_CFG_HI:`REF_CFG_LO];
    assign seq_per_irq = ctrl_two_r[`SPI_HI:`SPI_LO];
    assign sample_time = ctrl_three_r[`SAMP_HI:`SAMP_LO];
    // a write lands on the edge at which the master sees ack
    assign bus_wr      = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_r;

    // register writes, masked so unimplemented bits stay zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_two_r   <= `RESET_VALUE;
            ctrl_three_r <= `RESET_VALUE;
            ctrl_one_r   <= `RESET_VALUE;
        end else if (clk_en && bus_wr) begin
            if (wb_adr_i == `OFS_CTRL_TWO) begin
                if (wb_sel_i[0]) ctrl_two_r[7:0] <= wb_dat_i[7:0] & TWO_WMASK[7:0];
                if (wb_sel_i[1]) ctrl_two_r[15:8] <= wb_dat_i[15:8] & TWO_WMASK[15:8];
            end
            if (wb_adr_i == `OFS_CTRL_THREE) begin
                if (wb_sel_i[0]) ctrl_three_r[7:0] <= wb_dat_i[7:0] & THREE_WMASK[7:0];
                if (wb_sel_i[1]) ctrl_three_r[15:8] <= wb_dat_i[15:8] & THREE_WMASK[15:8];
            end
            if (wb_adr_i == `OFS_CTRL_ONE && wb_sel_i[0]) begin
                ctrl_one_r[7:0] <= wb_dat_i[7:0] & ONE_WMASK[7:0];
            end
        end
    end

    assign start_req = (bus_wr && wb_adr_i == `OFS_CTRL_ONE && wb_sel_i[0]
                        && wb_dat_i[`START_BIT]) || (trig_sync_r[1] && !trig_prev_r);

    // bus answer one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else if (clk_en) begin
            wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
            case (wb_adr_i)
                `OFS_CTRL_TWO:   wb_dat_r <= {16'h0000, ctrl_two_r[15:8],
                                              fill_half_status_r, 1'b0, ctrl_two_r[5:0]};
                `OFS_CTRL_THREE: wb_dat_r <= {16'h0000, ctrl_three_r};
                `OFS_CTRL_ONE:   wb_dat_r <= {16'h0000, ctrl_one_r & ~16'h0002};
                `OFS_RESULT:     wb_dat_r <= {16'h0000, 4'h0, state_r, slot_r, 6'h00};
                default:         wb_dat_r <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_ack_o = wb_ack_r;
    assign wb_dat_o = wb_dat_r;

    // conversion clock tick
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_count_r <= 8'h00;
        end else if (clk_en) begin
            if (ctrl_three_r[`CLK_SRC_BIT]) begin
                div_count_r <= 8'h00;
            end else if (div_count_r == ctrl_three_r[`DIV_HI:`DIV_LO]) begin
                div_count_r <= 8'h00;
            end else begin
                div_count_r <= div_count_r + 8'h01;
            end
        end
    end
    // bus clock path ticks every 2*(divider+1) cycles
    logic half_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_r <= 1'b0;
        end else if (clk_en && !ctrl_three_r[`CLK_SRC_BIT]) begin
            if (div_count_r == ctrl_three_r[`DIV_HI:`DIV_LO]) begin
                half_r <= !half_r;
            end
        end
    end
    // one tick per full period of the half flag, so 512 cycles fit an 8-bit count
    assign tick = ctrl_three_r[`CLK_SRC_BIT] ? (rc_sync_r[1] && !rc_prev_r)
                : (half_r && div_count_r == ctrl_three_r[`DIV_HI:`DIV_LO]);

    // sampling length: auto time only for trigger 111, else a single period
    assign sample_len = (ctrl_one_r[`TRIG_HI:`TRIG_LO] == `TRIG_AUTO) ? sample_time
                      : 5'h01;

    assign push_ok = !buf_full;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:    if (start_req) state_nxt = ST_SAMPLE;
            ST_SAMPLE:  if (tick && period_count_r >= sample_len - 5'h01) state_nxt = ST_CONVERT;
            ST_CONVERT: if (tick && period_count_r == `CONV_PERIODS) state_nxt = ST_DONE;
            ST_DONE:    if (push_ok) state_nxt = ST_IDLE;
            default:    state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r        <= ST_IDLE;
            period_count_r <= 5'h00;
        end else if (clk_en) begin
            state_r <= state_nxt;
            if (state_nxt != state_r) begin
                period_count_r <= 5'h00;
            end else if (tick) begin
                period_count_r <= period_count_r + 5'h01;
            end
        end
    end

    // sequence bookkeeping
    assign wr_en = (state_r == ST_DONE) && push_ok;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_count_r        <= 4'h0;
            slot_r             <= 4'h0;
            fill_half_status_r <= 1'b0;
            mux_b_r            <= 1'b0;
            first_sample_r     <= 1'b1;
            seq_irq_r          <= 1'b0;
        end else if (clk_en) begin
            seq_irq_r <= 1'b0;
            if (!ctrl_two_r[`ALT_BIT]) begin
                mux_b_r        <= 1'b0;
                first_sample_r <= 1'b1;
            end
            if (wr_en) begin
                if (ctrl_two_r[`ALT_BIT]) begin
                    mux_b_r        <= first_sample_r ? 1'b1 : !mux_b_r;
                    first_sample_r <= 1'b0;
                end
                if (seq_count_r == seq_per_irq) begin
                    seq_count_r <= 4'h0;
                    seq_irq_r   <= 1'b1;
                    if (ctrl_two_r[`SPLIT_BIT]) begin
                        fill_half_status_r <= !fill_half_status_r;
                        slot_r <= {!fill_half_status_r, 3'h0};
                    end else begin
                        slot_r <= 4'h0;
                    end
                end else begin
                    seq_count_r <= seq_count_r + 4'h1;
                    if (ctrl_two_r[`SPLIT_BIT]) begin
                        slot_r <= {fill_half_status_r, slot_r[2:0] + 3'h1};
                    end else begin
                        slot_r <= slot_r + 4'h1;
                    end
                end
            end
        end
    end
    assign seq_irq = seq_irq_r;

    // analog controls
    always_comb begin
        analog_ctrl.high_reference_ext = !ref_cfg[2] && ref_cfg[0];
        analog_ctrl.low_reference_ext  = !ref_cfg[2] && ref_cfg[1];
        analog_ctrl.inputs_to_low_ref  = ctrl_two_r[`OFFSET_CALIBRATION_ENABLE_BIT];
        analog_ctrl.use_scan_select    = !ctrl_two_r[`OFFSET_CALIBRATION_ENABLE_BIT] && ctrl_two_r[`SCAN_BIT];
        analog_ctrl.mux_b_select       = ctrl_two_r[`ALT_BIT] && mux_b_r;
        analog_ctrl.sample             = (state_r == ST_SAMPLE);
        analog_ctrl.convert            = (state_r == ST_CONVERT);
    end

    // two-entry result buffer
    assign buf_full = (count_r == 2'(DEPTH));
    assign rd_en    = result_valid && result_ready;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else if (clk_en) begin
            if (wr_en) wr_ptr_r <= !wr_ptr_r;
            if (rd_en) rd_ptr_r <= !rd_ptr_r;
            count_r <= count_r + 2'(wr_en) - 2'(rd_en);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (clk_en && wr_en) begin
            buf_mem[wr_ptr_r] <= '{slot: slot_r, value: conv_value};
        end
    end
    assign result_valid = (count_r != 2'h0);
    assign result_data  = result_valid ? buf_mem[rd_ptr_r] : '0;

endmodule : adc_sequence_clock_control

// *** tb/adc_core_model.sv ***
`timescale 1ns/1ns
module adc_core_model #(
    parameter logic [9:0] VAL_A = 10'h000,
    parameter logic [9:0] VAL_B = 10'h3FF
) (
    // clock and stall request
    input  wire logic                     sys_clk,
    input  wire logic                     stall,
    // converter side
    input  wire adc_seq_pkg::analog_ctrl_t analog_ctrl,
    output logic [9:0]                    conv_value,
    output logic                          rc_clk_tick,
    output logic                          result_ready
);
    logic [1:0] cnt_r = 2'h0;
    initial begin
        conv_value = 10'h000;
        rc_clk_tick = 1'b0;
        result_ready = 1'b0;
    end
    // rc oscillator runs free, 8 bus cycles a period
    always @(posedge sys_clk) begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == 2'h3) begin
            rc_clk_tick <= ~rc_clk_tick;
        end
        result_ready <= !stall;
        // held level tells which mux setting was sampled
        if (analog_ctrl.sample) begin
            conv_value <= analog_ctrl.mux_b_select ? VAL_B : VAL_A;
        end
    end
endmodule : adc_core_model

// *** tb/adc_seq_monitor.sv ***
`timescale 1ns/1ns
module adc_seq_monitor (
    // clock and reset
    input wire logic                     sys_clk,
    input wire logic                     clk_en,
    input wire logic                     resetn,
    // bus
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_we_i,
    input wire logic [3:0]               wb_adr_i,
    input wire logic [31:0]              wb_dat_i,
    input wire logic [31:0]              wb_dat_o,
    input wire logic                     wb_ack_o,
    // converter and stream
    input wire adc_seq_pkg::analog_ctrl_t analog_ctrl,
    input wire adc_seq_pkg::result_t     result_data,
    input wire logic                     result_valid,
    input wire logic                     result_ready,
    input wire logic                     seq_irq
);
    import adc_seq_pkg::*;
    logic [15:0] two_r;
    wire  [2:0]  rc = two_r[15:13];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // shadow of control two, taken at the acknowledged write
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            two_r <= 16'h0000;
        end else if (clk_en && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 4'h0) begin
            two_r <= wb_dat_i[15:0] & 16'hF43F;
        end
    end
    sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en; endsequence
    sequence rd_s; wb_ack_o && !wb_we_i; endsequence
    a_ack_answer: assert property (req_s |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ref_high: assert property (!wb_ack_o |-> analog_ctrl.high_reference_ext == (!rc[2] && rc[0]))
        else $error("high reference select wrong");
    a_ref_low: assert property (!wb_ack_o |-> analog_ctrl.low_reference_ext == (!rc[2] && rc[1]))
        else $error("low reference select wrong");
    a_offset_calibration_enable_tie: assert property (!wb_ack_o |-> analog_ctrl.inputs_to_low_ref == two_r[12])
        else $error("offset calibration routing wrong");
    a_scan_route: assert property (!wb_ack_o && !two_r[12] |-> analog_ctrl.use_scan_select == two_r[10])
        else $error("scan routing wrong");
    a_alt_off: assert property (!two_r[0] && analog_ctrl.sample |-> !analog_ctrl.mux_b_select)
        else $error("mux b used without alternation");
    a_unimpl_two: assert property ((rd_s and (wb_adr_i == 4'h0)) |-> (wb_dat_o & 32'hFFFF0B40) == 32'h0)
        else $error("unused bits of control two set");
    a_unimpl_three: assert property ((rd_s and (wb_adr_i == 4'h4)) |-> (wb_dat_o & 32'hFFFF6000) == 32'h0)
        else $error("unused bits of control three set");
    a_stream_hold: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
        else $error("stalled word lost");
    a_irq_pulse: assert property (seq_irq |=> !seq_irq)
        else $error("interrupt pulse too long");
endmodule : adc_seq_monitor

bind adc_sequence_clock_control adc_seq_monitor u_mon (.sys_clk, .clk_en, .resetn, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .analog_ctrl, .result_data,
    .result_valid, .result_ready, .seq_irq);

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import adc_seq_pkg::*;
    localparam logic [9:0] VAL_A = 10'h14A;
    localparam logic [9:0] VAL_B = 10'h2B5;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic stall = 1'b0;
    logic mtrig = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic ack, rc_tick, rdy, rvalid, irq;
    logic [9:0] cval;
    analog_ctrl_t actl;
    result_t rdata;
    result_t got[$];
    int num_errors = 0;
    int cmp_count = 0;
    int irq_n = 0;
    always #50 sys_clk = ~sys_clk;
    adc_sequence_clock_control #(.DEPTH(2)) DUT (.sys_clk(sys_clk), .clk_en(1'b1),
        .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .rc_clk_tick(rc_tick), .manual_trigger(mtrig), .conv_value(cval), .analog_ctrl(actl),
        .result_data(rdata), .result_valid(rvalid), .result_ready(rdy), .seq_irq(irq));
    adc_core_model #(.VAL_A(VAL_A), .VAL_B(VAL_B)) u_core (.sys_clk(sys_clk), .stall(stall),
        .analog_ctrl(actl), .conv_value(cval), .rc_clk_tick(rc_tick), .result_ready(rdy));
    always @(negedge sys_clk) begin
        if (rvalid === 1'b1 && rdy === 1'b1) got.push_back(rdata);
        if (irq === 1'b1) irq_n++;
    end
    task give_verdict;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task bail(input string nm);
        num_errors++;
        $display("ERROR %s expected done seen hang", nm);
        give_verdict();
    endtask : bail
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (n > 100) bail("ack");
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task wt(input bit smp, input logic v);
        int n;
        n = 0;
        while ((smp ? actl.sample : actl.convert) !== v) begin
            @(negedge sys_clk);
            n++;
            if (n > 3000) bail("sequencer");
        end
    endtask : wt
    task start(input logic [2:0] trig);
        wr(4'h8, {24'h0, trig, 5'h02});
    endtask : start
    task t_regs;
        logic [31:0] q;
        wb(1'b0, 4'h0, 32'h0, q);
        chk("two_reset", 32'h0, q);
        wb(1'b0, 4'h4, 32'h0, q);
        chk("three_reset", 32'h0, q);
        wr(4'h0, 32'hFFFFFFFF);
        wb(1'b0, 4'h0, 32'h0, q);
        chk("two_mask", 32'h0000F43F, q);
        wr(4'h4, 32'hFFFFFFFF);
        wb(1'b0, 4'h4, 32'h0, q);
        chk("three_mask", 32'h00009FFF, q);
        wr(4'h2, 32'hFFFFFFFF);
        wb(1'b0, 4'h2, 32'h0, q);
        chk("unmapped", 32'h0, q);
        $display("test regs done");
    endtask : t_regs
    task t_ref;
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(4'h0, {16'h0, c, c[2], 1'b0, c[0], 10'h000});
            @(negedge sys_clk);
            chk("ref_high", !c[2] && c[0], actl.high_reference_ext);
            chk("ref_low", !c[2] && c[1], actl.low_reference_ext);
            chk("to_low_ref", c[2], actl.inputs_to_low_ref);
            if (!c[2]) chk("scan_sel", c[0], actl.use_scan_select);
        end
        $display("test ref done");
    endtask : t_ref
    task t_samp;
        int r3[4] = '{32'h0301, 32'h0301, 32'h83FF, 32'h1F00};
        int tg[4] = '{7, 0, 0, 7};
        int lo[4] = '{8, 0, 0, 60};
        int hi[4] = '{12, 4, 8, 62};
        int n;
        wr(4'h0, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(4'h4, r3[i]);
            if (i == 1) begin
                wr(4'h8, 32'h0);
                mtrig <= 1'b1;
            end else begin
                start(3'(tg[i]));
            end
            wt(1'b1, 1'b1);
            n = 0;
            while (actl.sample === 1'b1 && n < 500) begin
                @(negedge sys_clk);
                n++;
            end
            chk("sample_len", 1, n > lo[i] && n <= hi[i]);
            if (i == 1) begin
                @(posedge sys_clk);
                mtrig <= 1'b0;
            end
            wt(1'b0, 1'b0);
        end
        $display("test sample done");
    endtask : t_samp
    task t_seq;
        logic [31:0] q;
        int n;
        wr(4'h4, 32'h0100);
        wr(4'h0, 32'h0B);
        got.delete();
        irq_n = 0;
        stall <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            if (k == 2) stall <= 1'b0;
            start(3'h0);
            wt(1'b0, 1'b1);
            wt(1'b0, 1'b0);
            if (k == 1) chk("stalled_word", 1, rvalid);
            if (k == 2) wb(1'b0, 4'h0, 32'h0, q);
            if (k == 2) chk("fill_upper", 1, q[7]);
        end
        n = 0;
        while (got.size() < 6 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        chk("irq_count", 2, irq_n);
        chk("word_count", 6, got.size());
        for (int k = 0; k < 6; k++) begin
            chk("slot", (k < 3) ? k : k + 5, got[k].slot);
            chk("value", (k % 2) ? VAL_B : VAL_A, got[k].value);
        end
        wb(1'b0, 4'h0, 32'h0, q);
        chk("fill_lower", 0, q[7]);
        $display("test sequence done");
    endtask : t_seq
    initial begin
        repeat (90000) @(posedge sys_clk);
        bail("watchdog");
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_ref();
        t_samp();
        t_seq();
        give_verdict();
    end
endmodule : tb_top
